// ### design/gcp_debounce.sv
`timescale 1ns/1ns
`default_nettype none
module gcp_debounce
	import gcp_pkg::*;
#(
	parameter int SHORT_CNT = 0,
	parameter int LONG_CNT  = 1
) (
	// clock and reset
	input wire logic   sys_clk,
	input wire logic   reset,
	// filtered line
	gcp_deb_if.filt    dl
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             lvl;
	logic             next_lvl;
	logic [CNT_W-1:0] lim;

	always_comb begin
		lim      = dl.sel_long ? CNT_W'(LONG_CNT) : CNT_W'(SHORT_CNT);
		next_cnt = '0;
		next_lvl = lvl;
		if (lim == '0) begin
			next_lvl = dl.raw;
		end else if (dl.raw != lvl) begin
			// glitches shorter than the period restart the count
			if (cnt == lim - CNT_W'(1)) begin
				next_lvl = dl.raw;
			end else begin
				next_cnt = cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt <= '0;
			lvl <= dl.raw; // start at the line's idle level, so no false edge follows reset
		end else begin
			cnt <= next_cnt;
			lvl <= next_lvl;
		end
	end

	assign dl.level = lvl;
endmodule
`default_nettype wire

// ### design/gcp_top.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - bias force bit high keeps main bias on; else on/off controller decides.
// - on-key style bit: 0 push-button, 1 slide-switch.
// - on-key debounce bit: 0 gives 500us, 1 gives 30ms.
// - soft power action code 00 does nothing.
// - code 01 powers down, resets, then powers up again unaided.
// - code 10 powers down, resets, then waits for a wake-up event.
// - code 11 powers down, resets config, opens battery switch, awaits ship exit.
// - power-down runs 60ms, 10.24ms, four 2.56ms slots, then 125ms discharge.
// - alternate bit high makes pin an active-high low-power enable input.
// - pin debounce bit: 0 none, 1 gives 30ms; resets to 0.
// - direction bit 0 output, 1 input; resets to input.
// - output value 0 drives low; 1 drives high or floats if open-drain.
// - drive type bit 0 open-drain, 1 push-pull; ignored for inputs.
// - input value bit reads the synchronised pin level after the pin debounce filter.
module gcp_top
	import gcp_pkg::*;
#(
	parameter int ONKEY_SHORT = ONKEY_SHORT_CYC,
	parameter int DEB_LONG    = DEB_LONG_CYC,
	parameter int T_INIT      = PD_INIT_CYC,
	parameter int T_RST       = PD_RST_CYC,
	parameter int T_SLOT      = PD_SLOT_CYC,
	parameter int T_DISCH     = PD_DISCH_CYC
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// register access port from the serial interface engine
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	// power controller side
	input  wire logic       onoff_bias_req,
	input  wire logic       wake_event,
	input  wire logic       ship_exit_event,
	output var  logic       main_bias_en,
	output var  logic [3:0] rail_en,
	output var  logic       discharge_en,
	output var  logic       reset_out_pin_n,
	output var  logic       batt_sys_open,
	// on-key pin
	input  wire logic       onkey_pin_n,
	output var  logic       onkey_level,
	output var  logic       onkey_input_style,
	// pin 0
	input  wire logic       pin0_in,
	output var  logic       pin0_out,
	output var  logic       pin0_oe,
	output var  logic       low_power_req
);
	// synchronisers: stage one feeds stage two only
	logic [3:0] sync1;
	logic [3:0] sync2;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync1 <= 4'h8; // idle levels: on-key high, pin and events low
			sync2 <= 4'h8;
		end else begin
			sync1 <= {onkey_pin_n, pin0_in, wake_event, ship_exit_event};
			sync2 <= sync1;
		end
	end

	gcp_deb_if onkey_if ();
	gcp_deb_if pin_if ();

	// configuration state
	logic [2:0]  glbl_upper;
	logic        bias_force;
	logic        onkey_sty;
	logic        onkey_deb;
	logic        pin_dir;
	logic        pin_drv;
	logic        pin_dout;
	logic        pin_deb;
	logic        pin_alt;
	gcp_pstate_e pst;
	logic [CNT_W-1:0] cnt;
	logic [1:0]  slot;
	logic [1:0]  act;

	logic [2:0]  next_glbl_upper;
	logic        next_bias_force;
	logic        next_onkey_sty;
	logic        next_onkey_deb;
	logic        next_pin_dir;
	logic        next_pin_drv;
	logic        next_pin_dout;
	logic        next_pin_deb;
	logic        next_pin_alt;
	gcp_pstate_e next_pst;
	logic [CNT_W-1:0] next_cnt;
	logic [1:0]  next_slot;
	logic [1:0]  next_act;
	logic        cfg_clear;
	logic        done;
	logic [CNT_W-1:0] lim;

	assign onkey_if.raw      = sync2[3];
	assign onkey_if.sel_long = onkey_deb;
	assign pin_if.raw        = sync2[2];
	assign pin_if.sel_long   = pin_deb;

	gcp_debounce #(.SHORT_CNT(ONKEY_SHORT), .LONG_CNT(DEB_LONG)) u_onkey_deb (
		.sys_clk (sys_clk),
		.reset   (reset),
		.dl      (onkey_if.filt)
	);
	// no short period: pin debounce off means pass-through
	gcp_debounce #(.SHORT_CNT(0), .LONG_CNT(DEB_LONG)) u_pin_deb (
		.sys_clk (sys_clk),
		.reset   (reset),
		.dl      (pin_if.filt)
	);

	// power-down sequencer
	always_comb begin
		next_pst  = pst;
		next_cnt  = cnt + CNT_W'(1);
		next_slot = slot;
		next_act  = act;
		cfg_clear = 1'b0;
		case (pst)
			PS_INIT:   lim = CNT_W'(T_INIT);
			PS_RSTDLY: lim = CNT_W'(T_RST);
			PS_SLOT:   lim = CNT_W'(T_SLOT);
			default:   lim = CNT_W'(T_DISCH);
		endcase
		done = (cnt == lim - CNT_W'(1));
		case (pst)
			PS_ON: begin
				next_cnt = '0;
				if (reg_wr && reg_addr == GCP_GLBL_ADDR && reg_wdata[1:0] != SFT_NONE) begin
					next_act = reg_wdata[1:0];
					next_pst = PS_INIT;
				end
			end
			PS_INIT: begin
				if (done) begin
					next_pst = PS_RSTDLY;
					next_cnt = '0;
				end
			end
			PS_RSTDLY: begin
				if (done) begin
					next_pst  = PS_SLOT;
					next_cnt  = '0;
					next_slot = 2'h0;
				end
			end
			PS_SLOT: begin
				if (done) begin
					next_cnt  = '0;
					next_slot = slot + 2'h1;
					if (slot == 2'(PD_SLOTS - 1)) begin
						next_pst = PS_DISCH;
					end
				end
			end
			PS_DISCH: begin
				if (done) begin
					next_cnt  = '0;
					cfg_clear = 1'b1;
					if (act == SFT_COLD_RST) begin
						next_pst = PS_ON;
					end else if (act == SOFT_POWER_OFF) begin
						next_pst = PS_OFF;
					end else begin
						next_pst = PS_SHIP;
					end
				end
			end
			PS_OFF: begin
				next_cnt = '0;
				if (sync2[1]) begin
					next_pst = PS_ON;
				end
			end
			default: begin
				next_cnt = '0;
				if (sync2[0]) begin
					next_pst = PS_ON;
				end
			end
		endcase
	end

	// register writes; commands are not stored, so the field reads 00
	always_comb begin
		next_glbl_upper = glbl_upper;
		next_bias_force = bias_force;
		next_onkey_sty  = onkey_sty;
		next_onkey_deb  = onkey_deb;
		next_pin_dir    = pin_dir;
		next_pin_drv    = pin_drv;
		next_pin_dout   = pin_dout;
		next_pin_deb    = pin_deb;
		next_pin_alt    = pin_alt;
		if (cfg_clear) begin
			next_glbl_upper = GLBL_UPPER_RST;
			next_bias_force = BIAS_FORCE_RST;
			next_onkey_sty  = ONKEY_STY_RST;
			next_onkey_deb  = ONKEY_DEB_RST;
			next_pin_dir    = PIN_DIR_RST;
			next_pin_drv    = PIN_DRV_RST;
			next_pin_dout   = PIN_OUT_RST;
			next_pin_deb    = PIN_DEB_RST;
			next_pin_alt    = PIN_ALT_RST;
		end else if (reg_wr && reg_addr == GCP_GLBL_ADDR) begin
			next_glbl_upper = reg_wdata[7:GLBL_UPPER_LSB];
			next_bias_force = reg_wdata[GLBL_BIAS_FORCE];
			next_onkey_sty  = reg_wdata[GLBL_ONKEY_STY];
			next_onkey_deb  = reg_wdata[GLBL_ONKEY_DEB];
		end else if (reg_wr && reg_addr == GCP_PIN0_ADDR) begin
			// bits 7 and 6 are not stored; input value bit is read-only
			next_pin_dir  = reg_wdata[PIN_DIR];
			next_pin_drv  = reg_wdata[PIN_DRV];
			next_pin_dout = reg_wdata[PIN_OUT];
			next_pin_deb  = reg_wdata[PIN_DEB];
			next_pin_alt  = reg_wdata[PIN_ALT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			glbl_upper <= GLBL_UPPER_RST;
			bias_force <= BIAS_FORCE_RST;
			onkey_sty  <= ONKEY_STY_RST;
			onkey_deb  <= ONKEY_DEB_RST;
			pin_dir    <= PIN_DIR_RST;
			pin_drv    <= PIN_DRV_RST;
			pin_dout   <= PIN_OUT_RST;
			pin_deb    <= PIN_DEB_RST;
			pin_alt    <= PIN_ALT_RST;
			pst        <= PS_ON;
			cnt        <= '0;
			slot       <= 2'h0;
			act        <= SFT_NONE;
		end else begin
			glbl_upper <= next_glbl_upper;
			bias_force <= next_bias_force;
			onkey_sty  <= next_onkey_sty;
			onkey_deb  <= next_onkey_deb;
			pin_dir    <= next_pin_dir;
			pin_drv    <= next_pin_drv;
			pin_dout   <= next_pin_dout;
			pin_deb    <= next_pin_deb;
			pin_alt    <= next_pin_alt;
			pst        <= next_pst;
			cnt        <= next_cnt;
			slot       <= next_slot;
			act        <= next_act;
		end
	end

	// registered outputs
	logic [7:0] next_rdata;
	logic [3:0] next_rail;
	always_comb begin
		next_rdata = reg_rdata;
		if (reg_rd) begin
			if (reg_addr == GCP_GLBL_ADDR) begin
				next_rdata = {glbl_upper, bias_force, onkey_sty, onkey_deb, SFT_NONE};
			end else if (reg_addr == GCP_PIN0_ADDR) begin
				next_rdata = {2'h0, pin_alt, pin_deb, pin_dout, pin_drv, pin_if.level, pin_dir};
			end else begin
				next_rdata = 8'h00;
			end
		end
		next_rail = rail_en;
		if (pst == PS_ON) begin
			next_rail = 4'hF;
		end else if (pst == PS_SLOT && done) begin
			next_rail[slot] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata         <= 8'h00;
			main_bias_en      <= 1'b0;
			rail_en           <= 4'hF;
			discharge_en      <= 1'b0;
			reset_out_pin_n   <= 1'b1;
			batt_sys_open     <= 1'b0;
			onkey_level       <= 1'b1;
			onkey_input_style <= 1'b0;
			pin0_out          <= 1'b0;
			pin0_oe           <= 1'b0;
			low_power_req     <= 1'b0;
		end else begin
			reg_rdata         <= next_rdata;
			main_bias_en      <= bias_force | onoff_bias_req;
			rail_en           <= next_rail;
			discharge_en      <= (pst == PS_DISCH);
			// reset output held low from the end of its delay until power-up
			reset_out_pin_n   <= (pst == PS_ON) || (pst == PS_INIT) || (pst == PS_RSTDLY);
			batt_sys_open     <= (pst == PS_SHIP);
			onkey_level       <= onkey_if.level;
			onkey_input_style <= onkey_sty;
			// alternate mode or input direction never drives the pin
			pin0_out          <= pin_dout;
			pin0_oe           <= !pin_alt && !pin_dir && (!pin_dout || pin_drv);
			low_power_req     <= pin_alt && pin_if.level;
		end
	end
endmodule
`default_nettype wire

// ### dv/gcp_host.sv
`timescale 1ns/1ns
`default_nettype none
module gcp_host (
	// register port
	input  wire logic       sys_clk,
	input  wire logic [7:0] reg_rdata,
	output var  logic [7:0] reg_addr,
	output var  logic       reg_wr,
	output var  logic [7:0] reg_wdata,
	output var  logic       reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = (a == 8'h11) ? (d & 8'h7F) : d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		// idle bus shows inverted junk, not the last value
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ### dv/gcp_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module gcp_top_chk (
	// watched ports
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       onoff_bias_req,
	input wire logic       onkey_pin_n,
	input wire logic       main_bias_en,
	input wire logic [3:0] rail_en,
	input wire logic       discharge_en,
	input wire logic       reset_out_pin_n,
	input wire logic       batt_sys_open,
	input wire logic       onkey_level,
	input wire logic       pin0_oe,
	input wire logic       low_power_req
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_BIAS: assert property (onoff_bias_req |=> main_bias_en)
		else $error("bias off on request");
	AST_PIN_RST: assert property ($fell(reset) |-> !pin0_oe)
		else $error("pin drives after reset");
	AST_RST_FIRST: assert property ($fell(reset_out_pin_n) |-> rail_en == 4'hF)
		else $error("reset out late");
	AST_SLOT0: assert property ($fell(rail_en[0]) |-> !reset_out_pin_n && rail_en[3:1] == 3'h7)
		else $error("slot 0 order");
	AST_SLOT3: assert property ($fell(rail_en[3]) |-> rail_en[2:0] == 3'h0)
		else $error("slot 3 order");
	AST_DISCH: assert property ($rose(discharge_en) |-> rail_en == 4'h0 ##1 discharge_en[*7])
		else $error("discharge phase");
	AST_SHIP: assert property (batt_sys_open |-> rail_en == 4'h0 && !discharge_en)
		else $error("ship state rails");
	AST_ALT: assert property (low_power_req |-> !pin0_oe)
		else $error("alt pin driven");
	AST_DEB: assert property ($changed(onkey_level) |-> onkey_level == $past(onkey_pin_n, 3))
		else $error("on-key glitch taken");
endmodule
bind gcp_top gcp_top_chk gcp_top_chk_i (.sys_clk, .reset, .onoff_bias_req, .onkey_pin_n, .main_bias_en,
	.rail_en, .discharge_en, .reset_out_pin_n, .batt_sys_open, .onkey_level, .pin0_oe, .low_power_req);
`default_nettype wire

// ### dv/gcp_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module gcp_top_tb
	import gcp_pkg::*;
;
	logic       sys_clk, reset, onoff_bias_req, wake_event, ship_exit_event, onkey_pin_n, pin_ext;
	logic       reg_wr, reg_rd, main_bias_en, discharge_en, reset_out_pin_n, batt_sys_open;
	logic       onkey_level, onkey_input_style, pin0_out, pin0_oe, low_power_req;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, d;
	logic [3:0] rail_en;
	int         err_total, compares, n;
	wire        pin0_in = pin0_oe ? pin0_out : pin_ext;
	// on-key short period stays at its real length
	gcp_top #(.DEB_LONG(8), .T_INIT(10), .T_RST(6), .T_SLOT(4), .T_DISCH(12)) gcp_top_i (
		.sys_clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .onoff_bias_req,
		.wake_event, .ship_exit_event, .main_bias_en, .rail_en, .discharge_en, .reset_out_pin_n,
		.batt_sys_open, .onkey_pin_n, .onkey_level, .onkey_input_style, .pin0_in, .pin0_out,
		.pin0_oe, .low_power_req);
	gcp_host gcp_host_i (.sys_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task chk(string s, logic [7:0] e, logic [7:0] v);
		compares++;
		if (v !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", s, e, v);
		end
	endtask
	task rdc(logic [7:0] a, logic [7:0] e);
		gcp_host_i.rd(a, rv);
		chk("reg", e, rv);
	endtask
	task cyc(int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task results;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task t_regs;
		rdc(8'h10, 8'h00);
		rdc(8'h11, 8'h01);
		rdc(8'h20, 8'h00);
		gcp_host_i.wr(8'h10, 8'h18);
		cyc(2);
		chk("bias", 8'h01, {7'h0, main_bias_en});
		chk("style", 8'h01, {7'h0, onkey_input_style});
		gcp_host_i.wr(8'h10, 8'h00);
		onoff_bias_req = 1'b1;
		cyc(2);
		chk("bias_req", 8'h01, {7'h0, main_bias_en});
		chk("style0", 8'h00, {7'h0, onkey_input_style});
		onoff_bias_req = 1'b0;
		$display("t_regs done");
	endtask
	task t_onkey;
		// short glitch first, then a press held past the period
		for (int s = 0; s < 2; s++) begin
			n = s ? 8 : ONKEY_SHORT_CYC;
			gcp_host_i.wr(8'h10, s ? 8'h04 : 8'h00);
			onkey_pin_n = 1'b0;
			cyc(n - 2);
			onkey_pin_n = 1'b1;
			cyc(6);
			chk("onkey_glitch", 8'h01, {7'h0, onkey_level});
			onkey_pin_n = 1'b0;
			cyc(n + 6);
			chk("onkey_press", 8'h00, {7'h0, onkey_level});
			onkey_pin_n = 1'b1;
			cyc(n + 6);
		end
		$display("t_onkey done");
	endtask
	task t_pin;
		logic [7:0] tbl[5] = '{8'h0C, 8'h08, 8'h00, 8'h04, 8'h0D};
		foreach (tbl[i]) begin
			d = tbl[i];
			gcp_host_i.wr(8'h11, d);
			cyc(5);
			chk("pin", {6'h0, !d[0] && (!d[3] || d[2]), d[3]}, {6'h0, pin0_oe, pin0_out});
			rdc(8'h11, d | {6'h0, !d[0] && d[3] && d[2], 1'b0});
		end
		pin_ext = 1'b1;
		gcp_host_i.wr(8'h11, 8'h21);
		cyc(5);
		chk("lowpow", 8'h01, {7'h0, low_power_req});
		gcp_host_i.wr(8'h11, 8'h11);
		pin_ext = 1'b0;
		cyc(4);
		pin_ext = 1'b1;
		rdc(8'h11, 8'h13);
		pin_ext = 1'b0;
		cyc(14);
		rdc(8'h11, 8'h11);
		$display("t_pin done");
	endtask
	task t_seq(logic [1:0] c);
		gcp_host_i.wr(8'h10, {6'h01, c});
		n = 0;
		while (reset_out_pin_n && n < 40) begin
			cyc(1);
			n++;
		end
		if (c == 2'h0) begin
			chk("no_action", 8'h1F, {3'h0, reset_out_pin_n, rail_en});
			$display("t_seq 0 done");
			return;
		end
		chk("rst_delay", 8'h01, {7'h0, n >= 14 && n <= 18});
		while (!discharge_en && n < 80) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (discharge_en && n < 40) begin
			cyc(1);
			n++;
		end
		chk("disch_len", 8'h01, {7'h0, n >= 11 && n <= 13});
		cyc(4);
		if (c == 2'h1) chk("restart", 8'h1F, {3'h0, reset_out_pin_n, rail_en});
		if (c == 2'h2) chk("off", 8'h00, {4'h0, rail_en});
		if (c == 2'h3) chk("ship", 8'h01, {7'h0, batt_sys_open});
		wake_event = (c == 2'h2);
		ship_exit_event = (c == 2'h3);
		cyc(8);
		wake_event = 1'b0;
		ship_exit_event = 1'b0;
		cyc(8);
		chk("wake", 8'h0F, {3'h0, batt_sys_open, rail_en});
		rdc(8'h10, 8'h00);
		cyc(4);
		$display("t_seq %0d done", c);
	endtask
	initial begin
		reset = 1'b1;
		{onoff_bias_req, wake_event, ship_exit_event, pin_ext} = 4'h0;
		onkey_pin_n = 1'b1;
		err_total = 0;
		compares = 0;
		repeat (12) @(negedge sys_clk);
		reset = 1'b0;
		t_regs();
		t_onkey();
		t_pin();
		for (int c = 0; c < 4; c++) t_seq(c[1:0]);
		results();
	end
	initial begin
		#(100 * 30000);
		err_total++;
		results();
	end
endmodule
`default_nettype wire

// ### include/gcp_deb_if.sv
`timescale 1ns/1ns
`default_nettype none
interface gcp_deb_if;
	logic raw;
	logic sel_long;
	logic level;
	modport filt (input raw, input sel_long, output level);
	modport user (output raw, output sel_long, input level);
endinterface
`default_nettype wire

// ### include/gcp_pkg.sv
package gcp_pkg;
	// register offsets
	localparam logic [7:0] GCP_GLBL_ADDR   = 8'h10;
	localparam logic [7:0] GCP_PIN0_ADDR   = 8'h11;
	// global configuration fields
	localparam int GLBL_SFT_LSB    = 0;
	localparam int GLBL_ONKEY_DEB  = 2;
	localparam int GLBL_ONKEY_STY  = 3;
	localparam int GLBL_BIAS_FORCE = 4;
	localparam int GLBL_UPPER_LSB  = 5;
	// pin0 configuration fields
	localparam int PIN_DIR   = 0;
	localparam int PIN_IN    = 1;
	localparam int PIN_DRV   = 2;
	localparam int PIN_OUT   = 3;
	localparam int PIN_DEB   = 4;
	localparam int PIN_ALT   = 5;
	// reset values (factory-programmed bits held at a plain default)
	localparam logic [2:0] GLBL_UPPER_RST  = 3'h0;
	localparam logic       BIAS_FORCE_RST  = 1'b0;
	localparam logic       ONKEY_STY_RST   = 1'b0;
	localparam logic       ONKEY_DEB_RST   = 1'b0;
	localparam logic       PIN_DIR_RST     = 1'b1;
	localparam logic       PIN_DRV_RST     = 1'b0;
	localparam logic       PIN_OUT_RST     = 1'b0;
	localparam logic       PIN_DEB_RST     = 1'b0;
	localparam logic       PIN_ALT_RST     = 1'b0;
	// soft power action codes
	localparam logic [1:0] SFT_NONE        = 2'h0;
	localparam logic [1:0] SFT_COLD_RST    = 2'h1;
	localparam logic [1:0] SOFT_POWER_OFF         = 2'h2;
	localparam logic [1:0] SFT_SHIP        = 2'h3;
	// timing, times in microseconds
	localparam int CLK_MHZ         = 10;
	localparam int ONKEY_SHORT_US  = 500;
	localparam int DEB_LONG_US     = 30000;
	localparam int PD_INIT_US      = 60000;
	localparam int PD_RST_US       = 10240;
	localparam int PD_SLOT_US      = 2560;
	localparam int PD_DISCH_US     = 125000;
	localparam int PD_SLOTS        = 4;
	localparam int ONKEY_SHORT_CYC = ONKEY_SHORT_US * CLK_MHZ;
	localparam int DEB_LONG_CYC    = DEB_LONG_US * CLK_MHZ;
	localparam int PD_INIT_CYC     = PD_INIT_US * CLK_MHZ;
	localparam int PD_RST_CYC      = PD_RST_US * CLK_MHZ;
	localparam int PD_SLOT_CYC     = PD_SLOT_US * CLK_MHZ;
	localparam int PD_DISCH_CYC    = PD_DISCH_US * CLK_MHZ;
	localparam int CNT_W           = 21;

	typedef enum logic [2:0] {
		PS_ON, PS_INIT, PS_RSTDLY, PS_SLOT, PS_DISCH, PS_OFF, PS_SHIP
	} gcp_pstate_e;
endpackage
